// ---- dbm_pkg.sv ----
package dbm_pkg;

	localparam int          DBM_TOTAL_BITS = 18432;
	localparam int          DBM_WORDS      = 512;
	localparam int          DBM_WORD_W     = 36;
	localparam int          DBM_PORT_W     = 18;
	localparam int          DBM_LANE_W     = 9;
	localparam int          DBM_ADDR_W     = 14;
	localparam int          DBM_WADDR_LSB  = 5;
	localparam int          DBM_WADDR_W    = DBM_ADDR_W - DBM_WADDR_LSB;
	localparam int          DBM_SEL_W      = 3;
	localparam int          DBM_WEN_W      = 2;

	localparam logic [2:0]  DBM_W_X1       = 3'h0;
	localparam logic [2:0]  DBM_W_X2       = 3'h1;
	localparam logic [2:0]  DBM_W_X4       = 3'h2;
	localparam logic [2:0]  DBM_W_X9       = 3'h3;
	localparam logic [2:0]  DBM_W_X18      = 3'h4;
	localparam logic [2:0]  DBM_W_X36      = 3'h5;

	localparam logic [2:0]  DBM_BLK_ALL    = 3'h7;
	localparam logic [17:0] DBM_DOUT_RST   = 18'h00000;

endpackage

// ---- dbm_store.sv ----
`timescale 1ns/100ps
module dbm_store
	import dbm_pkg::*;
#(
	parameter int DEPTH = DBM_WORDS,
	parameter int WIDTH = DBM_WORD_W,
	parameter int AW    = DBM_WADDR_W
) (
	input  wire logic             clock_in,
	input  wire logic             a_rd_in,
	input  wire logic [AW-1:0]    a_addr_in,
	input  wire logic [WIDTH-1:0] a_mask_in,
	input  wire logic [WIDTH-1:0] a_data_in,
	output logic      [WIDTH-1:0] a_word_out,
	input  wire logic             b_rd_in,
	input  wire logic [AW-1:0]    b_addr_in,
	input  wire logic [WIDTH-1:0] b_mask_in,
	input  wire logic [WIDTH-1:0] b_data_in,
	output logic      [WIDTH-1:0] b_word_out
);

	if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
		$error("dbm_store: depth does not fit the address width");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] a_word_reg;
	logic [WIDTH-1:0] b_word_reg;

	// Same-word read and write returns the old word; no collision guard
	always_ff @(posedge clock_in) begin
		if (a_rd_in) begin
			a_word_reg <= mem[a_addr_in];
		end
		if (b_rd_in) begin
			b_word_reg <= mem[b_addr_in];
		end
		for (int i = 0; i < WIDTH; i++) begin
			if (a_mask_in[i]) begin
				mem[a_addr_in][i] <= a_data_in[i];
			end
			// Port B last: it wins a same-bit double write
			if (b_mask_in[i]) begin
				mem[b_addr_in][i] <= b_data_in[i];
			end
		end
	end

	assign a_word_out = a_word_reg;
	assign b_word_out = b_word_reg;

endmodule // dbm_store

// ---- dbm_out_stage.sv ----
`timescale 1ns/100ps
module dbm_out_stage
	import dbm_pkg::*;
(
	input  wire logic                  clock_in,
	input  wire logic                  resetn_in,
	input  wire logic [DBM_PORT_W-1:0] data_in,
	input  wire logic                  pipe_select_low_in,
	input  wire logic                  pipe_enable_in,
	input  wire logic                  pipe_sync_clear_low_in,
	input  wire logic                  pipe_async_clear_low_in,
	output logic      [DBM_PORT_W-1:0] data_out
);

	logic [DBM_PORT_W-1:0] pipe_reg;
	logic [DBM_PORT_W-1:0] pipe_next;

	always_comb begin
		pipe_next = pipe_reg;
		if (pipe_enable_in) begin
			pipe_next = pipe_sync_clear_low_in ? data_in : DBM_DOUT_RST;
		end
	end

	// Async clear overrides every other input
	always_ff @(posedge clock_in or negedge pipe_async_clear_low_in) begin
		if (!pipe_async_clear_low_in) begin
			pipe_reg <= DBM_DOUT_RST;
		end else if (!resetn_in) begin
			pipe_reg <= DBM_DOUT_RST;
		end else begin
			pipe_reg <= pipe_next;
		end
	end

	// Unused register is bypassed: output is the register's next value, not a clocked one
	always_comb begin
		if (!pipe_select_low_in) begin
			data_out = pipe_reg;
		end else if (!pipe_async_clear_low_in) begin
			data_out = DBM_DOUT_RST;
		end else begin
			data_out = pipe_next;
		end
	end

endmodule // dbm_out_stage

// ---- dbm_block_memory.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Store 18,432 bits reachable through two independent ports A and B.
// - Dual-port mode: each port 18 bits or narrower, five depth/width shapes.
// - Any 36-bit port means two-port mode: A only reads, B only writes.
// - Address, data, block select and write enable captured on rising edge.
// - Each port starts its operation on its own rising clock edge; here both ports share clock_in.
// - Read data has optional pipeline register with enable and two clears.
// - Dual-port feed-through high shows written data on same port output.
// - Both ports may read one location together and get stored value.
// - Same-location read and write: read undefined, write stored, no detection.
// - Width select 000..100 narrow shapes, 101 or 11x two-port 36.
// - Write enable 00 reads; for 9 bits or less 01 writes.
// - For 16/18 bits, write enable bits are lower and upper byte enables.
// - Two-port reads always enabled; 36-bit write needs static write enables.
// - Lockout high blocks serial config access; busy shows serial access.
// - In dual-port mode a port works only with block select 111; else no access, data 0. Two-port 36 writes on B's select, reads on A's.
// - Feed-through low: read data holds its value during a write.
// - Unused pipeline register is transparent; async clear low forces 0. Here the bypassed output holds while pipe enable is low and is 0 on sync clear.
module dbm_block_memory
	import dbm_pkg::*;
#(
	parameter int WORDS = DBM_WORDS
) (
	input  wire logic                  clock_in,
	input  wire logic                  resetn_in,
	input  wire logic [DBM_ADDR_W-1:0] porta_addr_in,
	input  wire logic [DBM_SEL_W-1:0]  porta_block_select_in,
	input  wire logic [DBM_PORT_W-1:0] porta_din_in,
	input  wire logic [DBM_WEN_W-1:0]  porta_wen_in,
	input  wire logic [2:0]            porta_width_in,
	input  wire logic                  porta_feedthrough_select_in,
	input  wire logic                  porta_memory_reset_low_in,
	input  wire logic                  porta_power_enable_in,
	input  wire logic                  porta_pipe_select_low_in,
	input  wire logic                  porta_pipe_enable_in,
	input  wire logic                  porta_pipe_sync_clear_low_in,
	input  wire logic                  porta_pipe_async_clear_low_in,
	output logic      [DBM_PORT_W-1:0] porta_dout_out,
	input  wire logic [DBM_ADDR_W-1:0] portb_addr_in,
	input  wire logic [DBM_SEL_W-1:0]  portb_block_select_in,
	input  wire logic [DBM_PORT_W-1:0] portb_din_in,
	input  wire logic [DBM_WEN_W-1:0]  portb_wen_in,
	input  wire logic [2:0]            portb_width_in,
	input  wire logic                  portb_feedthrough_select_in,
	input  wire logic                  portb_memory_reset_low_in,
	input  wire logic                  portb_power_enable_in,
	input  wire logic                  portb_pipe_select_low_in,
	input  wire logic                  portb_pipe_enable_in,
	input  wire logic                  portb_pipe_sync_clear_low_in,
	input  wire logic                  portb_pipe_async_clear_low_in,
	output logic      [DBM_PORT_W-1:0] portb_dout_out,
	input  wire logic                  serial_config_lockout_in,
	input  wire logic                  serial_config_request_in,
	output logic                       serial_config_busy_out
);

	if (WORDS * DBM_WORD_W != DBM_TOTAL_BITS) begin : g_chk
		$error("dbm_block_memory: words times word width must be the total bits");
	end

	// Data bit k of a 32-bit word sits in lane k/8, skipping each parity bit
	function automatic logic [5:0] phys_bit(input logic [4:0] k);
		return ({4'h0, k[4:3]} * 6'h09) + {3'h0, k[2:0]};
	endfunction

	function automatic logic is_wide(input logic [2:0] w);
		return w >= DBM_W_X36;
	endfunction

	function automatic logic wants_write(input logic [2:0] w, input logic [1:0] wen);
		return (w <= DBM_W_X9) ? wen[0] : (|wen);
	endfunction

	function automatic logic [35:0] place_data(input logic [2:0] w, input logic [4:0] a,
			input logic [17:0] lo, input logic [17:0] hi);
		logic [35:0] d;
		logic [4:0]  k;
		d = '0;
		k = a;
		case (w)
			DBM_W_X1, DBM_W_X2, DBM_W_X4: begin
				for (int i = 0; i < 4; i++) begin
					k = a + 5'(i);
					if (i < (1 << w)) begin
						d[phys_bit(k)] = lo[i];
					end
				end
			end
			DBM_W_X9:  d[int'(a[4:3]) * DBM_LANE_W +: DBM_LANE_W] = lo[8:0];
			DBM_W_X18: d[int'(a[4]) * DBM_PORT_W +: DBM_PORT_W] = lo;
			default:   d = {hi, lo};
		endcase
		return d;
	endfunction

	function automatic logic [35:0] place_mask(input logic [2:0] w, input logic [4:0] a,
			input logic [1:0] wlo, input logic [1:0] whi);
		logic [35:0] m;
		logic [4:0]  k;
		m = '0;
		k = a;
		case (w)
			DBM_W_X1, DBM_W_X2, DBM_W_X4: begin
				for (int i = 0; i < 4; i++) begin
					k = a + 5'(i);
					if (i < (1 << w)) begin
						m[phys_bit(k)] = wlo[0];
					end
				end
			end
			DBM_W_X9:  m[int'(a[4:3]) * DBM_LANE_W +: DBM_LANE_W] = {9{wlo[0]}};
			DBM_W_X18: m[int'(a[4]) * DBM_PORT_W +: DBM_PORT_W] =
				{{9{wlo[1]}}, {9{wlo[0]}}};
			default:   m = {{9{whi[1]}}, {9{whi[0]}}, {9{wlo[1]}}, {9{wlo[0]}}};
		endcase
		return m;
	endfunction

	function automatic logic [17:0] pick_data(input logic [2:0] w, input logic [4:0] a,
			input logic [35:0] word);
		logic [17:0] r;
		logic [4:0]  k;
		r = '0;
		k = a;
		case (w)
			DBM_W_X1, DBM_W_X2, DBM_W_X4: begin
				for (int i = 0; i < 4; i++) begin
					k = a + 5'(i);
					if (i < (1 << w)) begin
						r[i] = word[phys_bit(k)];
					end
				end
			end
			DBM_W_X9:  r[8:0] = word[int'(a[4:3]) * DBM_LANE_W +: DBM_LANE_W];
			DBM_W_X18: r = word[int'(a[4]) * DBM_PORT_W +: DBM_PORT_W];
			default:   r = word[35:18];
		endcase
		return r;
	endfunction

	logic                   two_port;
	logic                   a_ok;
	logic                   b_ok;
	logic                   a_wr;
	logic                   b_wr;
	logic                   a_rd;
	logic                   b_rd;
	logic [35:0]            a_mask;
	logic [35:0]            b_mask;
	logic [35:0]            a_wdata;
	logic [35:0]            b_wdata;
	logic [35:0]            a_word;
	logic [35:0]            b_word;
	logic [17:0]            a_val;
	logic [17:0]            b_val;

	logic                   busy_reg;
	logic                   tp_reg;
	logic                   a_ok_reg;
	logic                   b_ok_reg;
	logic                   a_wr_reg;
	logic                   b_wr_reg;
	logic [4:0]             a_sub_reg;
	logic [4:0]             b_sub_reg;
	logic [DBM_PORT_W-1:0]  a_din_reg;
	logic [DBM_PORT_W-1:0]  b_din_reg;
	logic [DBM_PORT_W-1:0]  a_hold_reg;
	logic [DBM_PORT_W-1:0]  b_hold_reg;

	assign two_port = is_wide(porta_width_in) | is_wide(portb_width_in);

	// Serial config access suspends both user ports while it owns the array
	assign a_ok = (porta_block_select_in == DBM_BLK_ALL) & porta_memory_reset_low_in
		& porta_power_enable_in & ~busy_reg;
	assign b_ok = (portb_block_select_in == DBM_BLK_ALL) & portb_memory_reset_low_in
		& portb_power_enable_in & ~busy_reg;

	assign a_wr = a_ok & ~two_port & wants_write(porta_width_in, porta_wen_in);
	assign b_wr = b_ok & (is_wide(portb_width_in)
		? (|{porta_wen_in, portb_wen_in}) : wants_write(portb_width_in, portb_wen_in));
	assign a_rd = a_ok & (two_port | ~a_wr);
	assign b_rd = b_ok & ~two_port & ~b_wr;

	assign a_wdata = place_data(porta_width_in, porta_addr_in[4:0], porta_din_in, '0);
	assign a_mask  = a_wr ? place_mask(porta_width_in, porta_addr_in[4:0], porta_wen_in, '0)
		: '0;
	assign b_wdata = place_data(portb_width_in, portb_addr_in[4:0], portb_din_in,
		porta_din_in);
	assign b_mask  = b_wr ? place_mask(portb_width_in, portb_addr_in[4:0], portb_wen_in,
		porta_wen_in) : '0;

	// One shared array, both ports registered on the same edge
	dbm_store #(
		.DEPTH (WORDS),
		.WIDTH (DBM_WORD_W),
		.AW    (DBM_WADDR_W)
	) u_store (
		.clock_in   (clock_in),
		.a_rd_in    (a_rd),
		.a_addr_in  (porta_addr_in[DBM_ADDR_W-1:DBM_WADDR_LSB]),
		.a_mask_in  (a_mask),
		.a_data_in  (a_wdata),
		.a_word_out (a_word),
		.b_rd_in    (b_rd),
		.b_addr_in  (portb_addr_in[DBM_ADDR_W-1:DBM_WADDR_LSB]),
		.b_mask_in  (b_mask),
		.b_data_in  (b_wdata),
		.b_word_out (b_word)
	);

	// Sideband captured with the array access so read data lines up
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			tp_reg    <= 1'b0;
			a_ok_reg  <= 1'b0;
			b_ok_reg  <= 1'b0;
			a_wr_reg  <= 1'b0;
			b_wr_reg  <= 1'b0;
			a_sub_reg <= '0;
			b_sub_reg <= '0;
			a_din_reg <= DBM_DOUT_RST;
			b_din_reg <= DBM_DOUT_RST;
		end else begin
			tp_reg    <= two_port;
			a_ok_reg  <= a_ok;
			b_ok_reg  <= b_ok;
			a_wr_reg  <= a_wr;
			b_wr_reg  <= b_wr;
			a_sub_reg <= porta_addr_in[4:0];
			b_sub_reg <= portb_addr_in[4:0];
			a_din_reg <= porta_din_in;
			b_din_reg <= portb_din_in;
		end
	end

	// Read value valid right after the capture edge
	always_comb begin
		if (!a_ok_reg) begin
			a_val = DBM_DOUT_RST;
		end else if (a_wr_reg) begin
			a_val = porta_feedthrough_select_in ? a_din_reg : a_hold_reg;
		end else begin
			a_val = pick_data(porta_width_in, a_sub_reg, a_word);
		end
	end

	// Two-port 36-bit read drives the low half out of port B
	always_comb begin
		if (tp_reg) begin
			b_val = (a_ok_reg && is_wide(porta_width_in)) ? a_word[17:0] : DBM_DOUT_RST;
		end else if (!b_ok_reg) begin
			b_val = DBM_DOUT_RST;
		end else if (b_wr_reg) begin
			b_val = portb_feedthrough_select_in ? b_din_reg : b_hold_reg;
		end else begin
			b_val = pick_data(portb_width_in, b_sub_reg, b_word);
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			a_hold_reg <= DBM_DOUT_RST;
			b_hold_reg <= DBM_DOUT_RST;
		end else begin
			a_hold_reg <= a_val;
			b_hold_reg <= b_val;
		end
	end

	// Lockout keeps the serial path off the array entirely
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= serial_config_request_in & ~serial_config_lockout_in;
		end
	end

	assign serial_config_busy_out = busy_reg;

	dbm_out_stage u_out_a (
		.clock_in                (clock_in),
		.resetn_in               (resetn_in),
		.data_in                 (a_val),
		.pipe_select_low_in      (porta_pipe_select_low_in),
		.pipe_enable_in          (porta_pipe_enable_in),
		.pipe_sync_clear_low_in  (porta_pipe_sync_clear_low_in),
		.pipe_async_clear_low_in (porta_pipe_async_clear_low_in),
		.data_out                (porta_dout_out)
	);

	dbm_out_stage u_out_b (
		.clock_in                (clock_in),
		.resetn_in               (resetn_in),
		.data_in                 (b_val),
		.pipe_select_low_in      (portb_pipe_select_low_in),
		.pipe_enable_in          (portb_pipe_enable_in),
		.pipe_sync_clear_low_in  (portb_pipe_sync_clear_low_in),
		.pipe_async_clear_low_in (portb_pipe_async_clear_low_in),
		.data_out                (portb_dout_out)
	);

endmodule // dbm_block_memory

// ---- dbm_checker_sva.sv ----
`timescale 1ns/100ps
module dbm_checker
	import dbm_pkg::*;
(
	input wire logic                  clock_in,
	input wire logic                  resetn_in,
	input wire logic [DBM_SEL_W-1:0]  porta_block_select_in,
	input wire logic [DBM_PORT_W-1:0] porta_din_in,
	input wire logic [DBM_WEN_W-1:0]  porta_wen_in,
	input wire logic [2:0]            porta_width_in,
	input wire logic                  porta_feedthrough_select_in,
	input wire logic                  porta_pipe_select_low_in,
	input wire logic                  porta_pipe_enable_in,
	input wire logic                  porta_pipe_sync_clear_low_in,
	input wire logic                  porta_pipe_async_clear_low_in,
	input wire logic [DBM_PORT_W-1:0] porta_dout_out,
	input wire logic [2:0]            portb_width_in,
	input wire logic                  portb_pipe_select_low_in,
	input wire logic                  portb_pipe_enable_in,
	input wire logic                  portb_pipe_sync_clear_low_in,
	input wire logic                  portb_pipe_async_clear_low_in,
	input wire logic [DBM_PORT_W-1:0] portb_dout_out,
	input wire logic                  serial_config_lockout_in,
	input wire logic                  serial_config_request_in,
	input wire logic                  serial_config_busy_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	logic a_live;
	logic b_reg;
	// Port A transparent and passing data
	assign a_live = porta_pipe_select_low_in && porta_pipe_enable_in
		&& porta_pipe_sync_clear_low_in && porta_pipe_async_clear_low_in;
	assign b_reg = !portb_pipe_select_low_in && portb_pipe_async_clear_low_in;
	sequence s_a_write;
		a_live && porta_block_select_in == DBM_BLK_ALL && porta_wen_in != 2'h0
			&& !serial_config_busy_out && porta_width_in < DBM_W_X36
			&& portb_width_in < DBM_W_X36;
	endsequence
	sequence s_a_full;
		porta_feedthrough_select_in && porta_width_in == DBM_W_X18 && porta_wen_in == 2'h3;
	endsequence
	porta_block_select_off_zero: assert property (
		$past(porta_block_select_in) != DBM_BLK_ALL && a_live |-> porta_dout_out == 18'h00000)
		else $error("port A data not zero after deselect");
	a_feed_thru_data: assert property (s_a_write ##0 s_a_full
		|=> !a_live || porta_dout_out == $past(porta_din_in))
		else $error("feed-through data missing");
	a_write_hold_out: assert property (s_a_write ##0 !porta_feedthrough_select_in
		|=> !a_live || $stable(porta_dout_out))
		else $error("read data moved during write");
	a_async_clr_zero: assert property (
		!portb_pipe_async_clear_low_in |-> portb_dout_out == 18'h00000)
		else $error("async clear did not force zero");
	a_pipe_sync_clr: assert property (
		b_reg && portb_pipe_enable_in && !portb_pipe_sync_clear_low_in
		|=> !portb_pipe_async_clear_low_in || portb_dout_out == 18'h00000)
		else $error("sync clear did not zero register");
	a_pipe_hold_out: assert property (
		b_reg && !portb_pipe_enable_in |=> !portb_pipe_async_clear_low_in || $stable(portb_dout_out))
		else $error("disabled register changed");
	a_busy_locked: assert property (
		serial_config_lockout_in && $past(serial_config_lockout_in) |-> !serial_config_busy_out)
		else $error("busy while locked");
	a_busy_rise_one: assert property ($past(serial_config_request_in)
		&& !$past(serial_config_lockout_in) && $past(resetn_in) |-> serial_config_busy_out)
		else $error("busy missing after request");
	a_busy_drop_idle: assert property (
		!$past(serial_config_request_in) |-> !serial_config_busy_out)
		else $error("busy without request");
endmodule // dbm_checker

bind dbm_block_memory dbm_checker chk_i (.clock_in, .resetn_in, .porta_block_select_in,
	.porta_din_in, .porta_wen_in, .porta_width_in, .porta_feedthrough_select_in,
	.porta_pipe_select_low_in, .porta_pipe_enable_in, .porta_pipe_sync_clear_low_in,
	.porta_pipe_async_clear_low_in, .porta_dout_out, .portb_width_in,
	.portb_pipe_select_low_in, .portb_pipe_enable_in, .portb_pipe_sync_clear_low_in,
	.portb_pipe_async_clear_low_in, .portb_dout_out, .serial_config_lockout_in,
	.serial_config_request_in, .serial_config_busy_out);

// ---- dbm_fabric_port.sv ----
`timescale 1ns/100ps
module dbm_fabric_port
	import dbm_pkg::*;
(
	input  wire logic                  clock_in,
	output logic      [DBM_ADDR_W-1:0] addr_out,
	output logic      [DBM_SEL_W-1:0]  blk_out,
	output logic      [DBM_PORT_W-1:0] din_out,
	output logic      [DBM_WEN_W-1:0]  wen_out
);
	initial begin
		addr_out = 14'h0000;
		blk_out = 3'h0;
		din_out = 18'h00000;
		wen_out = 2'h0;
	end
	// Called at a falling edge; request held across the next rising edge
	task automatic op(input logic [13:0] a, input logic [17:0] d, input logic [1:0] w,
		input logic [2:0] b);
		addr_out = a;
		din_out = d;
		wen_out = w;
		blk_out = b;
		@(negedge clock_in);
	endtask
endmodule // dbm_fabric_port

// ---- test_dbm_block_memory.sv ----
`timescale 1ns/100ps
module test_dbm_block_memory import dbm_pkg::*;;
	logic        clock_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [13:0] porta_addr_in, portb_addr_in;
	logic [2:0]  porta_block_select_in, portb_block_select_in;
	logic [17:0] porta_din_in, portb_din_in, porta_dout_out, portb_dout_out, q;
	logic [1:0]  porta_wen_in, portb_wen_in;
	logic [2:0]  porta_width_in = 3'h4, portb_width_in = 3'h4;
	logic        porta_feedthrough_select_in = 1'b0, portb_feedthrough_select_in = 1'b0;
	logic        porta_pipe_select_low_in = 1'b1, portb_pipe_select_low_in = 1'b0;
	logic        porta_pipe_enable_in = 1'b1, portb_pipe_enable_in = 1'b1;
	logic        porta_pipe_sync_clear_low_in = 1'b1, portb_pipe_sync_clear_low_in = 1'b1;
	logic        porta_pipe_async_clear_low_in = 1'b1, portb_pipe_async_clear_low_in = 1'b1;
	logic        serial_config_lockout_in = 1'b0, serial_config_request_in = 1'b0;
	logic        serial_config_busy_out;
	int          err_total = 0;
	int          check_count = 0;
	always #5 clock_in = ~clock_in;
	dbm_fabric_port fa (.clock_in, .addr_out(porta_addr_in), .blk_out(porta_block_select_in),
		.din_out(porta_din_in), .wen_out(porta_wen_in));
	dbm_fabric_port fb (.clock_in, .addr_out(portb_addr_in), .blk_out(portb_block_select_in),
		.din_out(portb_din_in), .wen_out(portb_wen_in));
	dbm_block_memory uut (.clock_in, .resetn_in, .porta_addr_in, .porta_block_select_in,
		.porta_din_in, .porta_wen_in, .porta_width_in, .porta_feedthrough_select_in,
		.porta_memory_reset_low_in(1'b1), .porta_power_enable_in(1'b1),
		.porta_pipe_select_low_in, .porta_pipe_enable_in, .porta_pipe_sync_clear_low_in,
		.porta_pipe_async_clear_low_in, .porta_dout_out, .portb_addr_in, .portb_block_select_in,
		.portb_din_in, .portb_wen_in, .portb_width_in, .portb_feedthrough_select_in,
		.portb_memory_reset_low_in(1'b1), .portb_power_enable_in(1'b1),
		.portb_pipe_select_low_in, .portb_pipe_enable_in, .portb_pipe_sync_clear_low_in,
		.portb_pipe_async_clear_low_in, .portb_dout_out, .serial_config_lockout_in,
		.serial_config_request_in, .serial_config_busy_out);
	task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// Two edges so the piped port B has settled as well
	task automatic rd(input bit b, input logic [13:0] a);
		repeat (2) begin
			if (b) fb.op(a, 18'h00000, 2'h0, 3'h7);
			else fa.op(a, 18'h00000, 2'h0, 3'h7);
		end
		q = b ? portb_dout_out : porta_dout_out;
	endtask
	task automatic t_dual();
		fb.op(14'h3FE0, 18'h1A5A5, 2'h3, 3'h7);
		rd(0, 14'h3FE0);
		chk("top_word", q, 18'h1A5A5);
		fa.op(14'h0020, 18'h2A5A5, 2'h3, 3'h7);
		rd(1, 14'h0020);
		chk("b_word", q, 18'h2A5A5);
		fa.op(14'h0020, 18'h00000, 2'h1, 3'h7);
		fa.op(14'h0020, 18'h3FFFF, 2'h2, 3'h7);
		fork
			rd(0, 14'h0020);
			rd(1, 14'h0020);
		join
		chk("a_lanes", porta_dout_out, 18'h3FE00);
		chk("b_lanes", portb_dout_out, 18'h3FE00);
	endtask
	task automatic t_widths();
		logic [13:0] a;
		logic [17:0] e;
		for (int w = 0; w < 4; w++) begin
			a = 14'(w + 2) << 5;
			e = (w == 3) ? 18'h001FF : 18'((1 << (1 << w)) - 1);
			porta_width_in = 3'h4;
			fa.op(a, 18'h00000, 2'h3, 3'h7);
			porta_width_in = 3'(w);
			fa.op(a, e, 2'h1, 3'h7);
			rd(1, a);
			chk("narrow", q, e);
		end
		porta_width_in = 3'h4;
	endtask
	task automatic t_blk();
		logic [2:0] s[3] = '{3'h6, 3'h5, 3'h3};
		foreach (s[i]) begin
			fa.op(14'h0020, 18'h00000, 2'h3, s[i]);
			chk("blk_off", porta_dout_out, 18'h00000);
		end
		rd(0, 14'h0020);
		chk("blk_kept", q, 18'h3FE00);
	endtask
	task automatic t_feed();
		porta_feedthrough_select_in = 1'b1;
		fa.op(14'h0100, 18'h15555, 2'h3, 3'h7);
		chk("feed", porta_dout_out, 18'h15555);
		// Select kept until the written word has been shown for a full cycle
		rd(0, 14'h0020);
		porta_feedthrough_select_in = 1'b0;
		fa.op(14'h0100, 18'h0AAAA, 2'h3, 3'h7);
		chk("hold", porta_dout_out, 18'h3FE00);
		rd(0, 14'h0100);
		chk("stored", q, 18'h0AAAA);
	endtask
	task automatic t_two();
		porta_width_in = 3'h5;
		portb_width_in = 3'h6;
		fork
			fa.op(14'h0120, 18'h12345, 2'h3, 3'h0);
			fb.op(14'h0120, 18'h2BCDE, 2'h3, 3'h7);
		join
		repeat (2) fork
			fa.op(14'h0120, 18'h00000, 2'h3, 3'h7);
			fb.op(14'h0120, 18'h00000, 2'h3, 3'h0);
		join
		chk("two_hi", porta_dout_out, 18'h12345);
		chk("two_lo", portb_dout_out, 18'h2BCDE);
		porta_width_in = 3'h4;
		portb_width_in = 3'h4;
	endtask
	task automatic t_pipe();
		rd(1, 14'h0020);
		portb_pipe_enable_in = 1'b0;
		rd(1, 14'h0100);
		chk("pipe_hold", portb_dout_out, 18'h3FE00);
		portb_pipe_enable_in = 1'b1;
		portb_pipe_sync_clear_low_in = 1'b0;
		@(negedge clock_in);
		chk("pipe_sclr", portb_dout_out, 18'h00000);
		portb_pipe_sync_clear_low_in = 1'b1;
		rd(1, 14'h0020);
		portb_pipe_async_clear_low_in = 1'b0;
		#1 chk("pipe_aclr", portb_dout_out, 18'h00000);
		@(negedge clock_in);
		portb_pipe_async_clear_low_in = 1'b1;
	endtask
	task automatic t_serial();
		serial_config_lockout_in = 1'b1;
		serial_config_request_in = 1'b1;
		repeat (3) @(negedge clock_in);
		chk("locked", 18'(serial_config_busy_out), 18'h00000);
		serial_config_lockout_in = 1'b0;
		rd(0, 14'h0020);
		chk("busy", 18'(serial_config_busy_out), 18'h00001);
		chk("refused", porta_dout_out, 18'h00000);
		serial_config_request_in = 1'b0;
		repeat (2) @(negedge clock_in);
		chk("idle", 18'(serial_config_busy_out), 18'h00000);
		rd(0, 14'h0020);
		chk("intact", q, 18'h3FE00);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clock_in);
		chk("rst_a", porta_dout_out, 18'h00000);
		chk("rst_b", portb_dout_out, 18'h00000);
		resetn_in = 1'b1;
		@(negedge clock_in);
		t_dual();
		t_widths();
		t_blk();
		t_feed();
		t_two();
		t_pipe();
		t_serial();
		tally_and_finish();
	end
	// Far beyond the 70 or so cycles the run needs
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
endmodule // test_dbm_block_memory
